// [rtl/frc_pkg.sv]
// package: opcodes, register fields, states and timing of the flash command core
package frc_pkg;
	// timing
	localparam int CLK_PERIOD_NS = 25;
	localparam int SUS_READY_TIME_NS = 100000;
	localparam int SUS_READY_CYC = SUS_READY_TIME_NS / CLK_PERIOD_NS;
	localparam int SUS_CNT_W = 13;
	localparam logic [SUS_CNT_W-1:0] SUS_READY_LOAD = SUS_CNT_W'(SUS_READY_CYC);
	localparam logic [3:0] QUAD_EXIT_CLKS = 4'h2;

	// opcodes handled by the core
	localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
	localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
	localparam logic [7:0] OP_STATUS_READ = 8'h05;
	localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
	localparam logic [7:0] OP_FUNC_READ = 8'h48;
	localparam logic [7:0] OP_FUNC_WRITE = 8'h42;
	localparam logic [7:0] OP_QUAD_ENTRY = 8'h35;
	localparam logic [7:0] OP_QUAD_EXIT = 8'hF5;
	localparam logic [7:0] OP_SUSPEND_A = 8'h75;
	localparam logic [7:0] OP_SUSPEND_B = 8'hB0;
	localparam logic [7:0] OP_RESUME_A = 8'h7A;
	localparam logic [7:0] OP_RESUME_B = 8'h30;
	localparam logic [7:0] OP_RESET_ARM = 8'h66;
	localparam logic [7:0] OP_SOFT_RESET = 8'h99;

	// program and erase opcodes forwarded to the engine
	localparam int N_WRITE_OPS = 9;
	localparam logic [7:0] WRITE_OPS [N_WRITE_OPS] = '{
		8'h02, 8'h32, 8'h38, 8'hD7, 8'h20, 8'h52, 8'hD8, 8'hC7, 8'h60};
	localparam int N_PROG_OPS = 3;

	// accepted during any suspend
	localparam int N_SUS_ANY_OPS = 30;
	localparam logic [7:0] SUS_ANY_OPS [N_SUS_ANY_OPS] = '{
		8'h03, 8'h0B, 8'hBB, 8'h3B, 8'hEB, 8'h6B, 8'h0D, 8'hBD, 8'hED, 8'h05,
		8'h48, 8'h82, 8'h7A, 8'h30, 8'hAB, 8'hC0, 8'h63, 8'h83, 8'h61, 8'h81,
		8'h9F, 8'h90, 8'hAF, 8'h4B, 8'h5A, 8'h00, 8'h66, 8'h99, 8'h68, 8'h14};
	// accepted only while an erase is suspended
	localparam int N_SUS_ERASE_OPS = 8;
	localparam logic [7:0] SUS_ERASE_OPS [N_SUS_ERASE_OPS] = '{
		8'h02, 8'h32, 8'h38, 8'h06, 8'h75, 8'hB0, 8'h26, 8'h24};

	// status byte fields
	localparam int SR_BUSY = 0;
	localparam int SR_WR_LATCH = 1;
	localparam int SR_BP_LSB = 2;
	localparam int SR_QUAD_EN = 6;
	localparam int SR_LOCK = 7;
	localparam logic [3:0] SR_BP_RESET = 4'h0;
	// function byte fields
	localparam int FR_RST_DIS = 1;
	localparam int FR_PROG_SUS = 2;
	localparam int FR_ERASE_SUS = 3;
	localparam int FR_IRL_LSB = 4;

	typedef enum logic [1:0] {
		FRC_ENG_IDLE = 2'h0,
		FRC_ENG_PROGRAM = 2'h1,
		FRC_ENG_ERASE = 2'h2,
		FRC_ENG_CHIP_ERASE = 2'h3
	} frc_eng_op_t;

	typedef enum logic [1:0] {
		FRC_ST_IDLE = 2'b00,
		FRC_ST_OPCODE = 2'b01,
		FRC_ST_BODY = 2'b11,
		FRC_ST_HOLD = 2'b10
	} frc_state_t;
endpackage

// [rtl/frc_link_if.sv]
// interface: byte stream between the pin front end and the command core
`timescale 1ns/10ps
`default_nettype none
interface frc_link_if;
	logic quad;
	logic frame_start;
	logic frame_end;
	logic byte_vld;
	logic [7:0] rx_byte;
	logic [3:0] clk_cnt;
	logic tx_en;
	logic [7:0] tx_byte;
	modport rx (input quad, input tx_en, input tx_byte,
		output frame_start, output frame_end, output byte_vld, output rx_byte,
		output clk_cnt);
	modport core (output quad, output tx_en, output tx_byte,
		input frame_start, input frame_end, input byte_vld, input rx_byte,
		input clk_cnt);
endinterface
`default_nettype wire

// [rtl/frc_pin_rx.sv]
// module: pin synchroniser, serial/quad shifter and reply driver
`timescale 1ns/10ps
`default_nettype none
module frc_pin_rx (
	// clock and reset
	input wire logic mclk_in,
	input wire logic rst_n_in,
	// host pins
	input wire logic sck_in,
	input wire logic cs_n_in,
	input wire logic [3:0] io_in,
	output logic [3:0] io_out,
	output logic [3:0] io_oe_out,
	// core side
	frc_link_if.rx lnk
);
	typedef struct packed {
		logic [2:0] sck_s;
		logic [2:0] cs_s;
		logic [11:0] io_s;
		logic sck_f;
		logic cs_n_f;
		logic [3:0] io_f;
		logic [7:0] rx_sh;
		logic [2:0] bit_cnt;
		logic [3:0] clk_cnt;
		logic [7:0] tx_sh;
		logic [2:0] tx_cnt;
		logic byte_vld;
		logic frame_start;
		logic frame_end;
	} frc_pin_rx_state_t;

	frc_pin_rx_state_t q;
	frc_pin_rx_state_t n;
	logic rise;
	logic fall;
	logic [2:0] step;

	always_comb begin
		n = q;
		n.byte_vld = 1'b0;
		n.frame_start = 1'b0;
		n.frame_end = 1'b0;
		// three stages, a change counts once stages two and three agree
		n.sck_s = {q.sck_s[1:0], sck_in};
		n.cs_s = {q.cs_s[1:0], cs_n_in};
		n.io_s = {q.io_s[7:0], io_in};
		if (q.sck_s[1] == q.sck_s[2]) begin
			n.sck_f = q.sck_s[2];
		end
		if (q.cs_s[1] == q.cs_s[2]) begin
			n.cs_n_f = q.cs_s[2];
		end
		if (q.io_s[7:4] == q.io_s[11:8]) begin
			n.io_f = q.io_s[11:8];
		end
		rise = n.sck_f & ~q.sck_f;
		fall = ~n.sck_f & q.sck_f;
		step = lnk.quad ? 3'h4 : 3'h1;
		if (!n.cs_n_f && q.cs_n_f) begin
			n.frame_start = 1'b1;
			n.bit_cnt = 3'h0;
			n.clk_cnt = 4'h0;
			n.tx_cnt = 3'h0;
		end else if (n.cs_n_f && !q.cs_n_f) begin
			n.frame_end = 1'b1;
		end else if (!n.cs_n_f) begin
			if (rise) begin
				// most significant bit or nibble arrives first
				if (lnk.quad) begin
					n.rx_sh = {q.rx_sh[3:0], n.io_f};
				end else begin
					n.rx_sh = {q.rx_sh[6:0], n.io_f[0]};
				end
				n.bit_cnt = q.bit_cnt + step;
				n.byte_vld = (n.bit_cnt == 3'h0);
				if (q.clk_cnt != 4'hF) begin
					n.clk_cnt = q.clk_cnt + 4'h1;
				end
			end
			if (fall && lnk.tx_en) begin
				if (q.tx_cnt == 3'h0) begin
					n.tx_sh = lnk.tx_byte;
				end else if (lnk.quad) begin
					n.tx_sh = {q.tx_sh[3:0], 4'h0};
				end else begin
					n.tx_sh = {q.tx_sh[6:0], 1'b0};
				end
				n.tx_cnt = q.tx_cnt + step;
			end
		end
	end

	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			q <= '0;
			q.sck_s <= 3'h0;
			q.cs_s <= 3'h7;
			q.cs_n_f <= 1'b1;
		end else begin
			q <= n;
		end
	end

	assign lnk.frame_start = q.frame_start;
	assign lnk.frame_end = q.frame_end;
	assign lnk.byte_vld = q.byte_vld;
	assign lnk.rx_byte = q.rx_sh;
	assign lnk.clk_cnt = q.clk_cnt;
	assign io_out = lnk.quad ? q.tx_sh[7:4] : {2'b00, q.tx_sh[7], 1'b0};
	assign io_oe_out = (lnk.tx_en && !q.cs_n_f) ? (lnk.quad ? 4'hF : 4'h2) : 4'h0;
endmodule
`default_nettype wire

// [rtl/frc_cmd_core.sv]
// module: status/function register commands, quad mode and suspend/resume control
`timescale 1ns/10ps
`default_nettype none
module frc_cmd_core (
	// clock and reset
	input wire logic mclk_in,
	input wire logic rst_n_in,
	// host pins
	input wire logic sck_in,
	input wire logic cs_n_in,
	input wire logic [3:0] io_in,
	output logic [3:0] io_out,
	output logic [3:0] io_oe_out,
	// program/erase engine
	input wire logic eng_busy_in,
	input wire frc_pkg::frc_eng_op_t eng_op_in,
	output logic eng_suspend_out,
	output logic eng_resume_out,
	output logic wr_cmd_out,
	output logic [7:0] wr_opcode_out,
	// non-volatile updates and reset
	output logic nv_status_wr_out,
	output logic nv_func_wr_out,
	output logic soft_reset_out,
	// state seen by the rest of the device
	output logic [7:0] status_reg_out,
	output logic [7:0] func_reg_out,
	output logic quad_mode_out,
	output logic write_enable_latch_out
);
	typedef struct packed {
		frc_pkg::frc_state_t state;
		logic quad;
		logic wr_latch;
		logic busy;
		logic [3:0] bp;
		logic quad_en;
		logic sr_lock;
		logic rst_dis;
		logic [3:0] irl;
		logic prog_sus;
		logic erase_sus;
		logic rst_armed;
		logic [frc_pkg::SUS_CNT_W-1:0] sus_cnt;
		logic [7:0] opcode;
		logic [7:0] arg;
		logic got_arg;
		logic tx_en;
		logic [7:0] tx_byte;
		logic eng_suspend;
		logic eng_resume;
		logic wr_cmd;
		logic [7:0] wr_opcode;
		logic nv_status_wr;
		logic nv_func_wr;
		logic soft_reset;
	} frc_core_state_t;

	frc_core_state_t q;
	frc_core_state_t n;
	logic settling;
	logic suspended;

	frc_link_if lnk ();

	frc_pin_rx u_pin_rx (
		.mclk_in(mclk_in),
		.rst_n_in(rst_n_in),
		.sck_in(sck_in),
		.cs_n_in(cs_n_in),
		.io_in(io_in),
		.io_out(io_out),
		.io_oe_out(io_oe_out),
		.lnk(lnk.rx)
	);

	function automatic logic is_write_op(input logic [7:0] op);
		logic hit;
		hit = 1'b0;
		for (int i = 0; i < frc_pkg::N_WRITE_OPS; i++) begin
			if (op == frc_pkg::WRITE_OPS[i]) begin
				hit = 1'b1;
			end
		end
		return hit;
	endfunction

	function automatic logic is_suspend(input logic [7:0] op);
		return (op == frc_pkg::OP_SUSPEND_A) || (op == frc_pkg::OP_SUSPEND_B);
	endfunction

	function automatic logic is_resume(input logic [7:0] op);
		return (op == frc_pkg::OP_RESUME_A) || (op == frc_pkg::OP_RESUME_B);
	endfunction

	// filter of opcodes while a suspend is in force
	function automatic logic sus_allowed(input logic [7:0] op, input logic erase_sus);
		logic hit;
		hit = 1'b0;
		for (int i = 0; i < frc_pkg::N_SUS_ANY_OPS; i++) begin
			if (op == frc_pkg::SUS_ANY_OPS[i]) begin
				hit = 1'b1;
			end
		end
		for (int i = 0; i < frc_pkg::N_SUS_ERASE_OPS; i++) begin
			if (erase_sus && op == frc_pkg::SUS_ERASE_OPS[i]) begin
				hit = 1'b1;
			end
		end
		return hit;
	endfunction

	function automatic logic [7:0] status_byte(input frc_core_state_t s);
		logic [7:0] b;
		b = 8'h00;
		b[frc_pkg::SR_BUSY] = s.busy;
		b[frc_pkg::SR_WR_LATCH] = s.wr_latch;
		b[frc_pkg::SR_BP_LSB +: 4] = s.bp;
		b[frc_pkg::SR_QUAD_EN] = s.quad_en;
		b[frc_pkg::SR_LOCK] = s.sr_lock;
		return b;
	endfunction

	function automatic logic [7:0] func_byte(input frc_core_state_t s);
		logic [7:0] b;
		b = 8'h00;
		b[frc_pkg::FR_RST_DIS] = s.rst_dis;
		b[frc_pkg::FR_PROG_SUS] = s.prog_sus;
		b[frc_pkg::FR_ERASE_SUS] = s.erase_sus;
		b[frc_pkg::FR_IRL_LSB +: 4] = s.irl;
		return b;
	endfunction

	assign settling = (q.sus_cnt != '0);
	assign suspended = q.prog_sus | q.erase_sus;

	always_comb begin
		n = q;
		n.eng_suspend = 1'b0;
		n.eng_resume = 1'b0;
		n.wr_cmd = 1'b0;
		n.nv_status_wr = 1'b0;
		n.nv_func_wr = 1'b0;
		n.soft_reset = 1'b0;
		// suspend settle time: busy until the engine has paused
		if (settling) begin
			n.sus_cnt = q.sus_cnt - frc_pkg::SUS_CNT_W'(1);
		end
		n.busy = eng_busy_in | settling;
		case (q.state)
			frc_pkg::FRC_ST_IDLE: begin
				n.tx_en = 1'b0;
				if (lnk.frame_start) begin
					n.state = frc_pkg::FRC_ST_OPCODE;
					n.got_arg = 1'b0;
				end
			end
			frc_pkg::FRC_ST_OPCODE: begin
				if (lnk.frame_end) begin
					n.state = frc_pkg::FRC_ST_IDLE;
				end else if (lnk.byte_vld) begin
					n.opcode = lnk.rx_byte;
					n.state = frc_pkg::FRC_ST_BODY;
					if (settling && lnk.rx_byte != frc_pkg::OP_STATUS_READ) begin
						n.state = frc_pkg::FRC_ST_HOLD;
					end else if (suspended && !sus_allowed(lnk.rx_byte, q.erase_sus)) begin
						n.state = frc_pkg::FRC_ST_HOLD;
					end else if (lnk.rx_byte == frc_pkg::OP_STATUS_READ) begin
						n.tx_en = 1'b1;
						n.tx_byte = status_byte(q);
					end else if (lnk.rx_byte == frc_pkg::OP_FUNC_READ) begin
						n.tx_en = 1'b1;
						n.tx_byte = func_byte(q);
					end
				end
			end
			frc_pkg::FRC_ST_BODY: begin
				if (lnk.byte_vld && !q.got_arg) begin
					n.arg = lnk.rx_byte;
					n.got_arg = 1'b1;
				end
				// replies track live state so polling sees the busy bit fall
				if (q.opcode == frc_pkg::OP_STATUS_READ) begin
					n.tx_byte = status_byte(q);
				end else if (q.opcode == frc_pkg::OP_FUNC_READ) begin
					n.tx_byte = func_byte(q);
				end
				if (lnk.frame_end) begin
					n.state = frc_pkg::FRC_ST_IDLE;
					n.tx_en = 1'b0;
					n.rst_armed = (q.opcode == frc_pkg::OP_RESET_ARM);
					// reset only when the previous completed frame armed it
					if (q.opcode == frc_pkg::OP_SOFT_RESET && q.rst_armed) begin
						n.soft_reset = 1'b1;
						n.wr_latch = 1'b0;
					end
					if (q.opcode == frc_pkg::OP_WRITE_DISABLE) begin
						n.wr_latch = 1'b0;
					end
					if (q.opcode == frc_pkg::OP_WRITE_ENABLE) begin
						n.wr_latch = 1'b1;
					end
					// a frame cut before its data byte must not write anything
					if (q.opcode == frc_pkg::OP_STATUS_WRITE && q.wr_latch && q.got_arg
						&& !q.busy) begin
						n.bp = q.arg[frc_pkg::SR_BP_LSB +: 4];
						n.sr_lock = q.arg[frc_pkg::SR_LOCK];
						n.quad_en = q.arg[frc_pkg::SR_QUAD_EN];
						n.nv_status_wr = 1'b1;
						n.wr_latch = 1'b0;
					end
					if (q.opcode == frc_pkg::OP_FUNC_WRITE && q.wr_latch && q.got_arg
						&& !q.busy) begin
						// one-time bits can only be or-ed
						n.rst_dis = q.rst_dis | q.arg[frc_pkg::FR_RST_DIS];
						n.irl = q.irl | q.arg[frc_pkg::FR_IRL_LSB +: 4];
						n.nv_func_wr = 1'b1;
						n.wr_latch = 1'b0;
					end
					if (q.opcode == frc_pkg::OP_QUAD_ENTRY && !q.quad) begin
						n.quad = 1'b1;
					end
					if (q.opcode == frc_pkg::OP_QUAD_EXIT && q.quad
						&& lnk.clk_cnt == frc_pkg::QUAD_EXIT_CLKS) begin
						n.quad = 1'b0;
					end
					// the latch is spent when the command is taken, not when it ends
					if (is_write_op(q.opcode) && q.wr_latch && !eng_busy_in) begin
						n.wr_cmd = 1'b1;
						n.wr_opcode = q.opcode;
						n.wr_latch = 1'b0;
					end
					// either suspend code, in either mode
					// a suspend with the engine idle has nothing to pause
					if (is_suspend(q.opcode) && eng_busy_in) begin
						case (eng_op_in)
							frc_pkg::FRC_ENG_PROGRAM: begin
								n.prog_sus = 1'b1;
								n.wr_latch = 1'b0;
								n.sus_cnt = frc_pkg::SUS_READY_LOAD;
								n.eng_suspend = 1'b1;
							end
							frc_pkg::FRC_ENG_ERASE: begin
								n.erase_sus = 1'b1;
								n.wr_latch = 1'b0;
								n.sus_cnt = frc_pkg::SUS_READY_LOAD;
								n.eng_suspend = 1'b1;
							end
							frc_pkg::FRC_ENG_CHIP_ERASE: begin
								// whole-array erase runs on untouched
								n.prog_sus = q.prog_sus;
							end
							default: begin
								n.prog_sus = q.prog_sus;
							end
						endcase
					end
					// innermost suspend resumes first
					// a program started inside an erase suspend is the inner one
					if (is_resume(q.opcode)) begin
						if (q.prog_sus) begin
							n.prog_sus = 1'b0;
							n.eng_resume = 1'b1;
						end else if (q.erase_sus) begin
							n.erase_sus = 1'b0;
							n.eng_resume = 1'b1;
						end
					end
				end
			end
			frc_pkg::FRC_ST_HOLD: begin
				// refused frame: no reply and no state change beyond disarming the reset
				n.tx_en = 1'b0;
				if (lnk.frame_end) begin
					n.state = frc_pkg::FRC_ST_IDLE;
					// any other completed frame disarms the reset
					n.rst_armed = 1'b0;
				end
			end
			default: begin
				n.state = frc_pkg::FRC_ST_IDLE;
				n.tx_en = 1'b0;
			end
		endcase
	end

	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			q <= '0;
			q.state <= frc_pkg::FRC_ST_IDLE;
			q.bp <= frc_pkg::SR_BP_RESET;
		end else begin
			q <= n;
		end
	end

	// quad mode steers the front end's bit width
	assign lnk.quad = q.quad;
	assign lnk.tx_en = q.tx_en;
	assign lnk.tx_byte = q.tx_byte;

	assign eng_suspend_out = q.eng_suspend;
	assign eng_resume_out = q.eng_resume;
	assign wr_cmd_out = q.wr_cmd;
	assign wr_opcode_out = q.wr_opcode;
	assign nv_status_wr_out = q.nv_status_wr;
	assign nv_func_wr_out = q.nv_func_wr;
	assign soft_reset_out = q.soft_reset;
	assign status_reg_out = status_byte(q);
	assign func_reg_out = func_byte(q);
	assign quad_mode_out = q.quad;
	assign write_enable_latch_out = q.wr_latch;
endmodule
`default_nettype wire

// [bench/frc_cmd_core_properties.sv]
// checker: port-level properties of the flash command core
`timescale 1ns/10ps
`default_nettype none
module frc_cmd_core_properties (
	// clock and reset
	input wire logic mclk_in,
	input wire logic rst_n_in,
	// watched ports
	input wire logic cs_n_in,
	input wire logic eng_busy_in,
	input wire frc_pkg::frc_eng_op_t eng_op_in,
	input wire logic eng_suspend_out,
	input wire logic eng_resume_out,
	input wire logic wr_cmd_out,
	input wire logic [3:0] io_oe_out,
	input wire logic [7:0] status_reg_out,
	input wire logic [7:0] func_reg_out,
	input wire logic quad_mode_out,
	input wire logic write_enable_latch_out
);
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (!rst_n_in);
	logic [12:0] wip_cnt_q;
	logic sus_any;
	assign sus_any = func_reg_out[frc_pkg::FR_PROG_SUS] | func_reg_out[frc_pkg::FR_ERASE_SUS];
	// cycles of busy status while suspended and the engine is paused
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in || !(status_reg_out[0] && sus_any && !eng_busy_in))
			wip_cnt_q <= 13'h0000;
		else
			wip_cnt_q <= wip_cnt_q + 13'h0001;
	end
	AST_SUS_PULSE: assert property (eng_suspend_out |=> !eng_suspend_out)
		else $error("suspend pulse longer than one cycle");
	AST_SUS_SETS_FLAG: assert property (eng_suspend_out |-> ##[0:1] sus_any)
		else $error("suspend without flag");
	AST_PROG_FLAG: assert property (eng_suspend_out && $past(eng_op_in) == frc_pkg::FRC_ENG_PROGRAM
		|-> ##[0:1] func_reg_out[frc_pkg::FR_PROG_SUS])
		else $error("program suspend flag missing");
	AST_NO_CHIP_SUS: assert property (eng_suspend_out
		|-> $past(eng_op_in) != frc_pkg::FRC_ENG_CHIP_ERASE)
		else $error("chip erase suspended");
	AST_FLAG_LATCH: assert property ($rose(func_reg_out[frc_pkg::FR_PROG_SUS])
		|| $rose(func_reg_out[frc_pkg::FR_ERASE_SUS]) |-> !write_enable_latch_out)
		else $error("latch set with new suspend flag");
	AST_RES_CLEARS: assert property (eng_resume_out && !(func_reg_out[2] && func_reg_out[3])
		|-> ##[0:1] func_reg_out[3:2] == 2'b00)
		else $error("resume left flag set");
	AST_OTP: assert property (((($past(func_reg_out) & ~func_reg_out)) & 8'hF2) == 8'h00)
		else $error("one-time bit returned to zero");
	AST_SUS_READY: assert property (wip_cnt_q <= frc_pkg::SUS_READY_CYC + 8)
		else $error("suspend settle too long");
	AST_WR_NEEDS_WEL: assert property (wr_cmd_out
		|-> $past(write_enable_latch_out) && !write_enable_latch_out)
		else $error("write accepted without latch");
	AST_OE_MODE: assert property (io_oe_out != 4'h0
		|-> io_oe_out == (quad_mode_out ? 4'hF : 4'h2))
		else $error("reply lanes wrong for mode");
endmodule
bind frc_cmd_core frc_cmd_core_properties frc_cmd_core_properties_inst (.mclk_in(mclk_in),
	.rst_n_in(rst_n_in), .cs_n_in(cs_n_in), .eng_busy_in(eng_busy_in),
	.eng_op_in(eng_op_in), .eng_suspend_out(eng_suspend_out),
	.eng_resume_out(eng_resume_out), .wr_cmd_out(wr_cmd_out), .io_oe_out(io_oe_out),
	.status_reg_out(status_reg_out), .func_reg_out(func_reg_out),
	.quad_mode_out(quad_mode_out), .write_enable_latch_out(write_enable_latch_out));
`default_nettype wire

// [bench/frc_host_model.sv]
// host flash controller model driving the serial pins
`timescale 1ns/10ps
`default_nettype none
module frc_host_model (
	// host pins
	output logic sck_out,
	output logic cs_n_out,
	output logic [3:0] io_out,
	// resolved pin levels
	input wire logic [3:0] io_in
);
	logic quad = 1'b0;
	initial begin
		sck_out = 1'b0;
		cs_n_out = 1'b1;
		io_out = 4'hF;
	end
	// one frame; the last reply byte ends up in rd
	task automatic xfer(input logic [7:0] op, input logic [7:0] dat, input int nd,
		input int nrd, output logic [7:0] rd);
		logic [7:0] b;
		rd = 8'h00;
		#3 cs_n_out = 1'b0;
		for (int k = 0; k < 1 + nd + nrd; k++) begin
			b = (k == 0) ? op : dat;
			for (int j = 0; j < (quad ? 2 : 8); j++) begin
				if (quad)
					io_out = j ? b[3:0] : b[7:4];
				else
					io_out = {2'b11, ~b[7 - j], b[7 - j]};
				#100 sck_out = 1'b1;
				#50 rd = quad ? {rd[3:0], io_in} : {rd[6:0], io_in[1]};
				#50 sck_out = 1'b0;
			end
		end
		#100 cs_n_out = 1'b1;
		io_out = ~io_out;
		#400;
		if (op == frc_pkg::OP_QUAD_ENTRY)
			quad = 1'b1;
		if (op == frc_pkg::OP_QUAD_EXIT)
			quad = 1'b0;
	endtask
endmodule
`default_nettype wire

// [bench/frc_cmd_core_tb.sv]
// testbench: command sequences against the flash command core
`timescale 1ns/10ps
`default_nettype none
module frc_cmd_core_tb;
	logic mclk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic eng_busy_in = 1'b0;
	frc_pkg::frc_eng_op_t eng_op_in = frc_pkg::FRC_ENG_IDLE;
	logic sck, cs_n, eng_suspend_out, eng_resume_out, wr_cmd_out, nv_status_wr_out;
	logic nv_func_wr_out, soft_reset_out, quad_mode_out, write_enable_latch_out;
	logic [3:0] hio, io_out, io_oe_out, io_w;
	logic [7:0] wr_opcode_out, status_reg_out, func_reg_out, rd, latch8;
	logic [7:0] n_sus = 8'h00, n_res = 8'h00, n_wr = 8'h00, n_rst = 8'h00, n_sw = 8'h00;
	logic [7:0] n_fw = 8'h00;
	int fails = 0;
	int comparisons = 0;
	assign io_w = (io_oe_out & io_out) | (~io_oe_out & hio);
	assign latch8 = {7'h00, write_enable_latch_out};
	initial forever #12.5 mclk_in = ~mclk_in;
	always @(posedge mclk_in) begin
		n_sus <= n_sus + {7'h00, eng_suspend_out === 1'b1};
		n_res <= n_res + {7'h00, eng_resume_out === 1'b1};
		n_wr <= n_wr + {7'h00, wr_cmd_out === 1'b1};
		n_rst <= n_rst + {7'h00, soft_reset_out === 1'b1};
		n_sw <= n_sw + {7'h00, nv_status_wr_out === 1'b1};
		n_fw <= n_fw + {7'h00, nv_func_wr_out === 1'b1};
	end
	frc_cmd_core frc_cmd_core_inst (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .sck_in(sck),
		.cs_n_in(cs_n), .io_in(io_w), .io_out(io_out), .io_oe_out(io_oe_out),
		.eng_busy_in(eng_busy_in), .eng_op_in(eng_op_in), .eng_suspend_out(eng_suspend_out),
		.eng_resume_out(eng_resume_out), .wr_cmd_out(wr_cmd_out),
		.wr_opcode_out(wr_opcode_out), .nv_status_wr_out(nv_status_wr_out),
		.nv_func_wr_out(nv_func_wr_out), .soft_reset_out(soft_reset_out),
		.status_reg_out(status_reg_out), .func_reg_out(func_reg_out),
		.quad_mode_out(quad_mode_out), .write_enable_latch_out(write_enable_latch_out));
	frc_host_model frc_host_model_inst (.sck_out(sck), .cs_n_out(cs_n), .io_out(hio),
		.io_in(io_w));
	task tally_and_finish;
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task cmd(input logic [7:0] op, input logic [7:0] dat = 8'h00, input int nd = 0,
		input int nrd = 0);
		frc_host_model_inst.xfer(op, dat, nd, nrd, rd);
	endtask
	task eng(input logic busy, input frc_pkg::frc_eng_op_t op);
		@(negedge mclk_in);
		eng_busy_in = busy;
		eng_op_in = op;
	endtask
	task wait_wip;
		int n;
		n = 0;
		while (status_reg_out[0] !== 1'b0) begin
			@(negedge mclk_in);
			n++;
			if (n > frc_pkg::SUS_READY_CYC + 200) begin
				fails++;
				tally_and_finish();
			end
		end
	endtask
	initial begin
		repeat (16) @(negedge mclk_in);
		rst_n_in = 1'b1;
		repeat (4) @(negedge mclk_in);
		chk("status", 8'h00, status_reg_out);
		chk("func", 8'h00, func_reg_out);
		cmd(frc_pkg::OP_WRITE_ENABLE);
		chk("latch", 8'h01, latch8);
		cmd(frc_pkg::OP_WRITE_DISABLE);
		chk("latch", 8'h00, latch8);
		cmd(frc_pkg::OP_WRITE_ENABLE);
		cmd(frc_pkg::OP_STATUS_WRITE, 8'hBC, 1);
		chk("status", 8'hBC, status_reg_out);
		cmd(frc_pkg::OP_WRITE_ENABLE);
		cmd(frc_pkg::OP_STATUS_WRITE, 8'h40, 1);
		chk("status", 8'h40, status_reg_out);
		cmd(frc_pkg::OP_STATUS_READ, 8'h00, 0, 1);
		chk("status read", 8'h40, rd);
		eng(1'b1, frc_pkg::FRC_ENG_PROGRAM);
		cmd(frc_pkg::OP_STATUS_READ, 8'h00, 0, 1);
		chk("busy read", 8'h41, rd);
		eng(1'b0, frc_pkg::FRC_ENG_IDLE);
		cmd(frc_pkg::OP_WRITE_ENABLE);
		cmd(frc_pkg::OP_FUNC_WRITE, 8'hF2, 1);
		chk("func", 8'hF2, func_reg_out);
		cmd(frc_pkg::OP_FUNC_READ, 8'h00, 0, 1);
		chk("func read", 8'hF2, rd);
		cmd(frc_pkg::OP_WRITE_ENABLE);
		cmd(frc_pkg::OP_FUNC_WRITE, 8'h00, 1);
		chk("func", 8'hF2, func_reg_out);
		cmd(frc_pkg::OP_QUAD_ENTRY);
		chk("quad", 8'h01, {7'h00, quad_mode_out});
		cmd(frc_pkg::OP_STATUS_READ, 8'h00, 0, 1);
		chk("quad read", 8'h40, rd);
		cmd(frc_pkg::OP_QUAD_EXIT);
		chk("quad", 8'h00, {7'h00, quad_mode_out});
		for (int i = 0; i < 2; i++) begin
			eng(1'b1, i ? frc_pkg::FRC_ENG_ERASE : frc_pkg::FRC_ENG_PROGRAM);
			cmd(frc_pkg::OP_WRITE_ENABLE);
			cmd(i ? frc_pkg::OP_SUSPEND_B : frc_pkg::OP_SUSPEND_A);
			eng(1'b0, frc_pkg::FRC_ENG_IDLE);
			chk("suspends", 8'(i + 1), n_sus);
			chk("flags", i ? 8'h08 : 8'h04, func_reg_out & 8'h0C);
			chk("busy latch", 8'h01, status_reg_out & 8'h03);
			cmd(frc_pkg::OP_WRITE_ENABLE);
			chk("latch settle", 8'h00, latch8);
			wait_wip();
			cmd(frc_pkg::OP_WRITE_ENABLE);
			chk("latch sus", i ? 8'h01 : 8'h00, latch8);
			if (i) begin
				cmd(8'h02, 8'h00, 4);
				chk("writes", 8'h01, n_wr);
				chk("opcode", 8'h02, wr_opcode_out);
			end
			cmd(frc_pkg::OP_SOFT_RESET);
			chk("reset", 8'h00, n_rst);
			cmd(i ? frc_pkg::OP_RESUME_B : frc_pkg::OP_RESUME_A);
			chk("flags", 8'h00, func_reg_out & 8'h0C);
			chk("resumes", 8'(i + 1), n_res);
			eng(1'b1, i ? frc_pkg::FRC_ENG_ERASE : frc_pkg::FRC_ENG_PROGRAM);
			repeat (3200) @(negedge mclk_in);
			eng(1'b0, frc_pkg::FRC_ENG_IDLE);
		end
		eng(1'b1, frc_pkg::FRC_ENG_CHIP_ERASE);
		cmd(frc_pkg::OP_SUSPEND_A);
		chk("chip flags", 8'h00, func_reg_out & 8'h0C);
		chk("suspends", 8'h02, n_sus);
		eng(1'b0, frc_pkg::FRC_ENG_IDLE);
		cmd(frc_pkg::OP_RESET_ARM);
		cmd(frc_pkg::OP_SOFT_RESET);
		chk("reset", 8'h01, n_rst);
		chk("status writes", 8'h02, n_sw);
		chk("func writes", 8'h02, n_fw);
		tally_and_finish();
	end
endmodule
`default_nettype wire
